//--- hdl/sdc_pkg.sv
// Shared constants, encodings and carrier types for the SDRAM controller
package sdc_pkg;

  // =====================================================
  // Clock and timing figures
  localparam int CLK_PS      = 25000;   // 40 MHz pclk
  localparam int TWR_NS      = 14;      // write_recovery_time
  localparam int TRP_NS      = 19;      // row_close_period
  localparam int TRCD_NS     = 19;      // activate to read or write
  localparam int ROW_OPEN_TIME_NS     = 45;      // row_open_time, least
  localparam int ROW_OPEN_TIME_MAX_NS = 100000;  // row_open_time, longest
  localparam int TRC_NS      = 67;      // row_cycle_time
  localparam int TREFI_NS    = 7800;    // average refresh interval
  localparam int SELFREFRESH_EXIT_TIME_CK    = 1;       // selfrefresh_exit_time, cycles
  localparam int CAS_LAT     = 2;       // CAS latency set in the part
  localparam int SYNC_STAGES = 2;       // dq input synchroniser depth

  // Least times round up, longest times round down
  function automatic int cyc_up(input int ns);
    return (ns * 1000 + CLK_PS - 1) / CLK_PS;
  endfunction

  function automatic int cyc_dn(input int ns);
    return (ns * 1000) / CLK_PS;
  endfunction

  localparam logic [11:0] TWR_CYC     = 12'(cyc_up(TWR_NS));
  localparam logic [11:0] TRP_CYC     = 12'(cyc_up(TRP_NS));
  localparam logic [11:0] TRCD_CYC    = 12'(cyc_up(TRCD_NS));
  localparam logic [11:0] ROW_OPEN_TIME_CYC    = 12'(cyc_up(ROW_OPEN_TIME_NS));
  localparam logic [11:0] ROW_OPEN_TIME_MAX_CY = 12'(cyc_dn(ROW_OPEN_TIME_MAX_NS));
  localparam logic [11:0] TRC_CYC     = 12'(cyc_up(TRC_NS));
  localparam logic [11:0] TREFI_CYC   = 12'(cyc_dn(TREFI_NS));
  // Refresh falls due early so issue latency stays inside the interval
  localparam logic [11:0] REF_DUE_CYC = TREFI_CYC - 12'h010;
  localparam logic [11:0] SELFREFRESH_EXIT_TIME_CYC   = 12'(SELFREFRESH_EXIT_TIME_CK);
  // Read issue to capture: pin flop, CAS latency, sync, capture
  localparam logic [3:0]  RD_LAT      = 4'(CAS_LAT + SYNC_STAGES + 1);

  // =====================================================
  // APB register map (byte addresses)
  localparam logic [7:0] ADDR_CMD    = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RDATA  = 8'h0c;
  localparam logic [7:0] ADDR_WDATA  = 8'h10;

  // Field positions
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_BANK_LSB = 4;
  localparam int CMD_AP_BIT   = 6;
  localparam int CMD_ADDR_LSB = 16;
  localparam int CTRL_AREF    = 0;
  localparam int CTRL_SEXIT   = 1;
  localparam int WDATA_MASK   = 16;
  localparam int STAT_ERR     = 3;
  localparam int AUTOCLOSE    = 10;   // all_bank_autoclose_bit

  localparam logic       CTRL_AREF_RST = 1'b1;

  // =====================================================
  // Order opcodes
  localparam logic [3:0] OP_NOP  = 4'h0;
  localparam logic [3:0] OP_ACT  = 4'h1;
  localparam logic [3:0] OP_RD   = 4'h2;
  localparam logic [3:0] OP_WR   = 4'h3;
  localparam logic [3:0] OP_PRE  = 4'h4;
  localparam logic [3:0] OP_PREA = 4'h5;
  localparam logic [3:0] OP_BST  = 4'h6;
  localparam logic [3:0] OP_REF  = 4'h7;
  localparam logic [3:0] OP_SREF = 4'h8;

  // Pin command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PC_NOP = 4'h7;
  localparam logic [3:0] PC_ACT = 4'h3;
  localparam logic [3:0] PC_RD  = 4'h5;
  localparam logic [3:0] PC_WR  = 4'h4;
  localparam logic [3:0] PC_PRE = 4'h2;
  localparam logic [3:0] PC_BST = 4'h6;
  localparam logic [3:0] PC_REF = 4'h1;

  typedef struct packed {
    logic        cke;
    logic [3:0]  cmd;    // {cs_n, ras_n, cas_n, we_n}
    logic [1:0]  ba;     // {bank_select_high, bank_select_low}
    logic [12:0] addr;
    logic        dqm;
  } sdc_pins_s;

  localparam sdc_pins_s PINS_RST = '{cke: 1'b1, cmd: PC_NOP, ba: 2'h0,
                                     addr: 13'h0000, dqm: 1'b1};

  typedef struct packed {
    logic [12:0] addr;
    logic        ap;
    logic [1:0]  bank;
    logic [3:0]  op;
  } sdc_order_s;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_PREALL  = 3'h1,
    ST_WAIT_RP = 3'h3,
    ST_REFRESH = 3'h2,
    ST_WAIT_RC = 3'h6,
    ST_SELF    = 3'h7,
    ST_EXIT    = 3'h5
  } sdc_state_e;

endpackage

//--- hdl/sdc_bank.sv
// Per-bank row state and timing tracker
`timescale 1ns/1ps
module sdc_bank
  import sdc_pkg::*;
(
  input  logic pclk,
  input  logic presetn,
  input  logic act,
  input  logic pre,
  input  logic rw,
  input  logic wr,
  input  logic ap,
  output logic is_open,
  output logic ap_pend,
  output logic act_ok,
  output logic rw_ok,
  output logic pre_ok,
  output logic idle_ok,
  output logic ras_expired
);

  logic [11:0] since_act;
  logic [11:0] rp_cnt;
  logic [11:0] wr_cnt;

  // =====================================================
  // Timing terms
  wire ras_met  = since_act >= ROW_OPEN_TIME_CYC;
  wire wr_done  = wr_cnt == 12'h000;
  wire ap_fire  = ap_pend & wr_done & ras_met;
  wire close    = (pre | ap_fire) & is_open;

  assign act_ok      = ~is_open & ~ap_pend & (rp_cnt == 12'h000)
                       & (since_act >= TRC_CYC);
  assign rw_ok       = is_open & ~ap_pend & (since_act >= TRCD_CYC);
  assign pre_ok      = ~is_open | (~ap_pend & wr_done & ras_met);
  assign idle_ok     = ~is_open & ~ap_pend & (rp_cnt == 12'h000);
  assign ras_expired = is_open & (since_act >= ROW_OPEN_TIME_MAX_CY);

  // Row open flag; close on a bank already closed is ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      is_open <= 1'b0;
    end else if (act) begin
      is_open <= 1'b1;
    end else if (close) begin
      is_open <= 1'b0;
    end
  end

  // Auto precharge follows write recovery and least row time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ap_pend <= 1'b0;
    end else if (rw & ap) begin
      ap_pend <= 1'b1;
    end else if (ap_fire) begin
      ap_pend <= 1'b0;
    end
  end

  // Cycles since activate, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_act <= 12'hfff;
    end else if (act) begin
      since_act <= 12'h000;
    end else if (since_act != 12'hfff) begin
      since_act <= since_act + 12'h001;
    end
  end

  // Row close period countdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_cnt <= 12'h000;
    end else if (close) begin
      rp_cnt <= TRP_CYC;
    end else if (rp_cnt != 12'h000) begin
      rp_cnt <= rp_cnt - 12'h001;
    end
  end

  // Write recovery countdown
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cnt <= 12'h000;
    end else if (wr) begin
      wr_cnt <= TWR_CYC;
    end else if (wr_cnt != 12'h000) begin
      wr_cnt <= wr_cnt - 12'h001;
    end
  end

endmodule

//--- hdl/sdc_ctrl.sv
// SDRAM command controller with APB register port
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
// Function
// - Precharge only after write recovery time
// - Mask words during recovery before precharge
// - Activate only after row close period
// - Never terminate an auto precharge burst
// - Activate row before read or write
// - No bank command until auto precharge done
// - Row open between least and longest time
// - Times round up to whole cycles; the code rounds the longest row open time and the refresh interval down
// - Write interrupting read: mask two cycles prior; the code starts no order until rd_cnt is zero, so no write interrupts a read
// - All idle before refresh, row cycle after
// - Refresh at least every 7.8 us
// - Stable clock, cke high, then NOPs
// - Extra refresh after self refresh exit
// - Row cycle time at least 67 ns
// - Wait exit time after raising cke
module sdc_ctrl
  import sdc_pkg::*;
(
  input  logic        pclk,
  input  logic        presetn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  output sdc_pins_s   pins,
  output logic [15:0] dq_out,
  output logic        dq_oe_n,
  input  logic [15:0] dq_in
);

  sdc_state_e  state;
  sdc_state_e  next_state;
  sdc_pins_s   next_pins;
  sdc_order_s  ord;
  logic        ord_valid;
  logic [15:0] wdata;
  logic        wmask;
  logic [15:0] rdata;
  logic        rd_valid;
  logic        err;
  logic        aref_en;
  logic        exit_req;
  logic        ref_due;
  logic        goal_ref;
  logic        goal_self;
  logic        last_ap;
  logic [11:0] ref_cnt;
  logic [11:0] trc_cnt;
  logic [3:0]  rd_cnt;
  logic [15:0] dq_meta;
  logic [15:0] dq_sync;
  logic [3:0]  b_open;
  logic [3:0]  b_ap;
  logic [3:0]  b_act_ok;
  logic [3:0]  b_rw_ok;
  logic [3:0]  b_pre_ok;
  logic [3:0]  b_idle_ok;
  logic [3:0]  b_ras_exp;
  logic        do_act;
  logic        do_rw;
  logic        do_wr;
  logic        do_pre;
  logic        do_prea;
  logic        do_ref;
  logic        drop;
  logic        drop_err;
  logic        set_goal_ref;
  logic        set_goal_self;

  function automatic logic [3:0] onehot(input logic [1:0] b);
    return 4'h1 << b;
  endfunction

  // =====================================================
  // APB decode
  wire acc      = psel & penable;
  wire wr_acc   = acc & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire hit_cmd  = paddr == ADDR_CMD;
  wire hit_ctrl = paddr == ADDR_CTRL;
  wire hit_stat = paddr == ADDR_STATUS;
  wire hit_rd   = paddr == ADDR_RDATA;
  wire hit_wd   = paddr == ADDR_WDATA;
  wire mapped   = hit_cmd | hit_ctrl | hit_stat | hit_rd | hit_wd;
  wire busy     = ord_valid | (rd_cnt != 4'h0) | (state != ST_IDLE);
  wire cmd_wr   = wr_acc & hit_cmd & ~busy;
  wire rd_clear = acc & ~pwrite & hit_rd;
  wire err_clr  = wr_acc & hit_stat & pwdata[STAT_ERR];
  wire in_self  = state == ST_SELF;

  assign pready  = 1'b1;
  assign pslverr = acc & (~mapped | (pwrite & hit_cmd & busy));

  wire [31:0] status = {23'h0, ref_due, b_open, err, rd_valid,
                        in_self, busy};
  wire [31:0] rd_mux = hit_cmd  ? {3'h0, ord.addr, 9'h0, ord.ap,
                                   ord.bank, ord.op} :
                       hit_ctrl ? {30'h0, exit_req, aref_en} :
                       hit_stat ? status :
                       hit_rd   ? {16'h0, rdata} :
                       hit_wd   ? {15'h0, wmask, wdata} : 32'h0;

  // Read data latched in setup for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // Order register, taken only while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ord_valid <= 1'b0;
      ord       <= '0;
    end else if (cmd_wr) begin
      ord_valid <= 1'b1;
      ord       <= '{addr: pwdata[CMD_ADDR_LSB +: 13],
                     ap:   pwdata[CMD_AP_BIT],
                     bank: pwdata[CMD_BANK_LSB +: 2],
                     op:   pwdata[CMD_OP_LSB +: 4]};
    end else if (drop) begin
      ord_valid <= 1'b0;
    end
  end

  // Control and write data registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aref_en <= CTRL_AREF_RST;
      wdata   <= 16'h0;
      wmask   <= 1'b0;
    end else begin
      if (wr_acc & hit_ctrl) aref_en <= pwdata[CTRL_AREF];
      if (wr_acc & hit_wd) wdata <= pwdata[15:0];
      if (wr_acc & hit_wd) wmask <= pwdata[WDATA_MASK];
    end
  end

  // Sticky flags, a set beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err      <= 1'b0;
      rd_valid <= 1'b0;
      exit_req <= 1'b0;
    end else begin
      err      <= drop_err | (err & ~err_clr);
      rd_valid <= (rd_cnt == 4'h1) | (rd_valid & ~rd_clear);
      // Exit request lapses once the exit sequence has begun
      exit_req <= (wr_acc & hit_ctrl & pwdata[CTRL_SEXIT])
                  | (exit_req & ~in_self & (state != ST_EXIT));
    end
  end

  // =====================================================
  // Bank trackers
  wire [3:0] sel     = onehot(ord.bank);
  wire [3:0] pre_vec = do_prea ? 4'hf : (do_pre ? sel : 4'h0);
  for (genvar i = 0; i < 4; i++) begin : g_bank
    sdc_bank u_bank (
      .pclk        (pclk),
      .presetn     (presetn),
      .act         (do_act & sel[i]),
      .pre         (pre_vec[i]),
      .rw          (do_rw & sel[i]),
      .wr          (do_wr & sel[i]),
      .ap          (ord.ap),
      .is_open     (b_open[i]),
      .ap_pend     (b_ap[i]),
      .act_ok      (b_act_ok[i]),
      .rw_ok       (b_rw_ok[i]),
      .pre_ok      (b_pre_ok[i]),
      .idle_ok     (b_idle_ok[i]),
      .ras_expired (b_ras_exp[i])
    );
  end

  // =====================================================
  // Order sequencer
  wire b_is_open = |(b_open & sel);
  wire b_is_ap   = |(b_ap & sel);
  wire all_pre   = &b_pre_ok;
  wire all_idle  = &b_idle_ok;
  wire trc_done  = trc_cnt == 12'h000;
  wire can_go    = ord_valid & (rd_cnt == 4'h0);

  always_comb begin
    next_state    = state;
    do_act        = 1'b0;
    do_rw         = 1'b0;
    do_wr         = 1'b0;
    do_pre        = 1'b0;
    do_prea       = 1'b0;
    do_ref        = 1'b0;
    drop          = 1'b0;
    drop_err      = 1'b0;
    set_goal_ref  = 1'b0;
    set_goal_self = 1'b0;
    case (state)
      ST_IDLE: begin
        if (ref_due) begin
          next_state   = ST_PREALL;
          set_goal_ref = 1'b1;
        end else if (|b_ras_exp) begin
          next_state = ST_PREALL;
        end else if (can_go) begin
          case (ord.op)
            OP_ACT: begin
              drop_err = b_is_open;
              do_act   = ~b_is_open & (sel == (b_act_ok & sel))
                         & trc_done;
            end
            OP_RD, OP_WR: begin
              drop_err = ~b_is_open & ~b_is_ap;
              do_rw    = |(b_rw_ok & sel);
              do_wr    = do_rw & (ord.op == OP_WR);
            end
            OP_PRE:  do_pre  = |(b_pre_ok & sel);
            OP_PREA: do_prea = all_pre;
            OP_BST:  begin
              drop_err = last_ap;
              drop     = ~last_ap;
            end
            OP_REF: begin
              next_state   = ST_PREALL;
              set_goal_ref = 1'b1;
              drop         = 1'b1;
            end
            OP_SREF: begin
              next_state    = ST_PREALL;
              set_goal_self = 1'b1;
              drop          = 1'b1;
            end
            default: drop = 1'b1;
          endcase
          drop = drop | drop_err | do_act | do_rw | do_pre | do_prea;
        end
      end
      ST_PREALL: begin
        do_prea = all_pre & trc_done;
        if (do_prea) next_state = ST_WAIT_RP;
      end
      ST_WAIT_RP: begin
        if (all_idle) begin
          next_state = (goal_ref | goal_self) ? ST_REFRESH : ST_IDLE;
        end
      end
      ST_REFRESH: begin
        do_ref     = 1'b1;
        next_state = goal_self ? ST_SELF : ST_WAIT_RC;
      end
      ST_WAIT_RC: begin
        if (trc_done) next_state = ST_IDLE;
      end
      ST_SELF: begin
        if (exit_req) next_state = ST_EXIT;
      end
      ST_EXIT: begin
        if (trc_done) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Pin word for the next cycle; mask stays high except on an unmasked write
  wire [12:0] rw_addr = {ord.addr[12:11], ord.ap, ord.addr[9:0]};
  wire [12:0] pa_addr = 13'h1 << AUTOCLOSE;
  wire        bst_go  = can_go & (state == ST_IDLE) & (ord.op == OP_BST)
                        & ~last_ap & ~ref_due & ~(|b_ras_exp);
  always_comb begin
    next_pins      = PINS_RST;
    next_pins.ba   = ord.bank;
    next_pins.addr = ord.addr;
    next_pins.cke  = ~((state == ST_SELF) & ~exit_req)
                     & ~(do_ref & goal_self);
    next_pins.dqm  = ~(do_wr & ~wmask);
    if (do_act) next_pins.cmd = PC_ACT;
    if (do_rw) next_pins.cmd = do_wr ? PC_WR : PC_RD;
    if (do_rw) next_pins.addr = rw_addr;
    if (do_pre) next_pins.cmd = PC_PRE;
    if (do_pre) next_pins.addr = 13'h0;
    if (do_prea) next_pins.cmd = PC_PRE;
    if (do_prea) next_pins.addr = pa_addr;
    if (bst_go) next_pins.cmd = PC_BST;
    if (do_ref) next_pins.cmd = PC_REF;
  end

  // State, pins and write data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ST_IDLE;
      pins    <= PINS_RST;
      dq_out  <= 16'h0;
      dq_oe_n <= 1'b1;
    end else begin
      state   <= next_state;
      pins    <= next_pins;
      dq_out  <= do_wr ? wdata : dq_out;
      dq_oe_n <= ~do_wr;
    end
  end

  // Refresh goals and last access mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      goal_ref  <= 1'b0;
      goal_self <= 1'b0;
      last_ap   <= 1'b0;
    end else begin
      goal_ref  <= set_goal_ref | (goal_ref & ~do_ref);
      goal_self <= set_goal_self | (goal_self & ~do_ref);
      if (do_rw) last_ap <= ord.ap;
    end
  end

  // Refresh interval timer; due flag set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt <= 12'h000;
      ref_due <= 1'b0;
    end else begin
      ref_cnt <= (do_ref | ref_cnt == REF_DUE_CYC) ? 12'h000
                 : ref_cnt + 12'h001;
      ref_due <= (aref_en & ref_cnt == REF_DUE_CYC)
                 | (state == ST_SELF & exit_req)
                 | (ref_due & ~do_ref);
    end
  end

  // Row cycle hold after refresh and self refresh exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trc_cnt <= 12'h000;
    end else if (do_ref) begin
      trc_cnt <= TRC_CYC;
    end else if (state == ST_SELF) begin
      trc_cnt <= TRC_CYC + SELFREFRESH_EXIT_TIME_CYC;
    end else if (trc_cnt != 12'h000) begin
      trc_cnt <= trc_cnt - 12'h001;
    end
  end

  // Read data path: two-stage sync then capture at fixed latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_meta <= 16'h0;
      dq_sync <= 16'h0;
      rd_cnt  <= 4'h0;
      rdata   <= 16'h0;
    end else begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
      rd_cnt  <= (do_rw & ~do_wr) ? RD_LAT
                 : (rd_cnt != 4'h0) ? rd_cnt - 4'h1 : 4'h0;
      if (rd_cnt == 4'h1) rdata <= dq_sync;
    end
  end

endmodule

//--- dv/sdc_ctrl_properties.sv
// Pin protocol checker bound to the SDRAM controller
`timescale 1ns/1ps
module sdc_ctrl_properties
  import sdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input sdc_pins_s pins
);
  logic [3:0] open_q;
  logic       ap_q;
  logic [9:0] gap;
  // ==========================================
  // Bank tracking decoded from the pins
  wire        rw  = pins.cmd == PC_RD || pins.cmd == PC_WR;
  wire        pre = pins.cmd == PC_PRE;
  wire        ac  = pins.addr[AUTOCLOSE];
  wire  [3:0] bit_b = 4'h1 << pins.ba;
  wire  [3:0] shut = (pre && ac) ? 4'hf : (pre || (rw && ac)) ? bit_b : 4'h0;
  wire  [3:0] opens = (pins.cmd == PC_ACT) ? bit_b : 4'h0;

  // Open rows, last autoclose choice, cycles since refresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_q <= 4'h0;
      ap_q   <= 1'b0;
      gap    <= 10'h000;
    end else begin
      open_q <= (open_q & ~shut) | opens;
      ap_q   <= rw ? ac : ap_q;
      gap    <= (pins.cmd == PC_REF || !pins.cke) ? 10'h000 : gap + 10'h001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mask_idle: assert property (pins.cmd != PC_WR |-> pins.dqm)
    else $error("mask low outside a write");
  a_ras_min: assert property (pins.cmd == PC_ACT |=> pins.cmd != PC_PRE)
    else $error("row closed too soon");
  a_rp_min: assert property (pre |=> pins.cmd != PC_ACT)
    else $error("activate inside close period");
  a_ref_nops: assert property (
    pins.cmd == PC_REF && pins.cke |=> pins.cmd == PC_NOP [*2])
    else $error("command inside row cycle after refresh");
  a_ref_closed: assert property (pins.cmd == PC_REF |-> open_q == 4'h0)
    else $error("refresh with a row open");
  a_rw_open: assert property (rw |-> open_q[pins.ba])
    else $error("access to a closed bank");
  a_exit_nops: assert property (
    $rose(pins.cke) |-> pins.cmd == PC_NOP [*4])
    else $error("command too early after exit");
  a_sref_entry: assert property ($fell(pins.cke) |-> pins.cmd == PC_REF)
    else $error("clock enable dropped without refresh");
  a_bst_plain: assert property (pins.cmd == PC_BST |-> !ap_q)
    else $error("terminate after autoclose access");
  a_ref_gap: assert property (gap < 10'h138)
    else $error("refresh interval exceeded");
endmodule

bind sdc_ctrl sdc_ctrl_properties u_props (
  .pclk    (pclk),
  .presetn (presetn),
  .pins    (pins)
);

//--- dv/sdc_mem_model.sv
// Behavioural four-bank SDRAM device facing the controller
`timescale 1ns/1ps
module sdc_mem_model
  import sdc_pkg::*;
(
  input  wire logic        clk,
  input  sdc_pins_s        pins,
  input  wire logic [15:0] dq_wr,
  output logic      [15:0] dq_rd
);
  logic [15:0] mem [bit [23:0]];
  logic [12:0] row [4];
  logic [3:0]  open = 4'h0;
  logic        cke_q = 1'b1;
  logic        sref = 1'b0;
  logic [1:0]  vld = 2'h0;
  logic [15:0] rd0, rd1;
  logic [15:0] last = 16'h0;
  wire  [23:0] key = {pins.ba, row[pins.ba], pins.addr[8:0]};
  wire         live = open[pins.ba];
  wire         ac = pins.addr[AUTOCLOSE];

  // Idle bus shows the inverse of the last word, never a stale copy
  assign dq_rd = vld[1] ? rd1 : ~last;

  // Command decode, gated by clock enable of the cycle before
  always @(posedge clk) begin
    vld <= {vld[0], 1'b0};
    rd1 <= rd0;
    if (vld[1])
      last <= rd1;
    if (cke_q && !sref) begin
      case (pins.cmd)
        PC_ACT: begin
          row[pins.ba] <= pins.addr;
          open[pins.ba] <= 1'b1;
        end
        PC_PRE: open <= ac ? 4'h0 : open & ~(4'h1 << pins.ba);
        PC_WR: begin
          if (live && !pins.dqm)
            mem[key] = dq_wr;
          if (ac)
            open[pins.ba] <= 1'b0;
        end
        PC_RD: begin
          rd0 <= (live && mem.exists(key)) ? mem[key] : ~last;
          vld[0] <= 1'b1;
          if (ac)
            open[pins.ba] <= 1'b0;
        end
        PC_REF: sref <= !pins.cke;
        default: ;
      endcase
    end else if (sref && pins.cke)
      sref <= 1'b0;
    cke_q <= pins.cke;
  end
endmodule

//--- dv/sdc_ctrl_tb.sv
// Self-checking bench for the SDRAM controller
`timescale 1ns/1ps
module sdc_ctrl_tb
  import sdc_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic        pready, pslverr, dq_oe_n, e;
  sdc_pins_s   pins;
  logic [15:0] dq_out, dq_in;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          refs = 0;

  always #12.5 pclk = ~pclk;

  sdc_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
  sdc_mem_model u_mem (.clk(pclk), .pins(pins), .dq_wr(dq_out),
    .dq_rd(dq_in));

  // Count auto refreshes the device registers, those issued with cke high
  always @(posedge pclk) if (pins.cmd == PC_REF && pins.cke) refs++;

  // ==========================================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      miscompares++;
      summarize();
    end
  endtask

  // Poll status until the sequencer is free
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    if (n >= 40) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic order(input logic [3:0] op, input logic [1:0] b,
                       input logic ap, input logic [12:0] ad);
    apb(1'b1, ADDR_CMD, {3'h0, ad, 9'h000, ap, b, op});
    idle();
  endtask

  task automatic rd_chk(input logic [1:0] b, input logic [12:0] c,
                        input logic [15:0] exp);
    order(OP_RD, b, 1'b0, c);
    apb(1'b0, ADDR_RDATA, 32'h0);
    chk(q, {16'h0, exp});
  endtask

  // Compare and clear the error flag
  task automatic err_chk(input logic exp);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({31'h0, q[STAT_ERR]}, {31'h0, exp});
    apb(1'b1, ADDR_STATUS, 32'h8);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk({27'h0, pins.cke, pins.cmd}, {27'h0, 1'b1, PC_NOP});
    chk({31'h0, pins.dqm}, 32'h1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk({31'h0, q[CTRL_AREF]}, {31'h0, CTRL_AREF_RST});
    apb(1'b0, 8'h14, 32'h0);
    chk({q[30:0], e}, 32'h1);
  endtask

  task automatic t_write();
    order(OP_ACT, 2'h1, 1'b0, 13'h0123);
    apb(1'b1, ADDR_WDATA, 32'h0000a55a);
    order(OP_WR, 2'h1, 1'b0, 13'h0005);
    apb(1'b1, ADDR_WDATA, 32'h00011234);
    order(OP_WR, 2'h1, 1'b0, 13'h0005);
    rd_chk(2'h1, 13'h0005, 16'ha55a);
    order(OP_BST, 2'h1, 1'b0, 13'h0000);
    err_chk(1'b0);
    apb(1'b1, ADDR_WDATA, 32'h00005aa5);
    order(OP_WR, 2'h1, 1'b1, 13'h0006);
    order(OP_BST, 2'h1, 1'b0, 13'h0000);
    err_chk(1'b1);
    order(OP_RD, 2'h1, 1'b0, 13'h0006);
    err_chk(1'b1);
    order(OP_ACT, 2'h1, 1'b0, 13'h0123);
    rd_chk(2'h1, 13'h0006, 16'h5aa5);
  endtask

  task automatic t_pre();
    int n;
    order(OP_ACT, 2'h2, 1'b0, 13'h0042);
    order(OP_ACT, 2'h3, 1'b0, 13'h0042);
    apb(1'b1, ADDR_WDATA, 32'h00000f0f);
    order(OP_WR, 2'h3, 1'b0, 13'h0001);
    order(OP_PREA, 2'h0, 1'b0, 13'h0000);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({28'h0, q[7:4]}, 32'h0);
    order(OP_RD, 2'h2, 1'b0, 13'h0001);
    err_chk(1'b1);
    order(OP_ACT, 2'h3, 1'b0, 13'h0042);
    rd_chk(2'h3, 13'h0001, 16'h0f0f);
    order(OP_PRE, 2'h3, 1'b0, 13'h0000);
    order(OP_PRE, 2'h3, 1'b0, 13'h0000);
    err_chk(1'b0);
    n = refs;
    order(OP_REF, 2'h0, 1'b0, 13'h0000);
    chk(32'(refs > n), 32'h1);
  endtask

  task automatic t_sref();
    int n;
    n = 0;
    apb(1'b1, ADDR_CMD, {28'h0, OP_SREF});
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (q[1] !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      summarize();
    end
    chk({31'h0, pins.cke}, 32'h0);
    n = refs;
    apb(1'b1, ADDR_CTRL, 32'h3);
    idle();
    chk({31'h0, q[1]}, 32'h0);
    order(OP_ACT, 2'h3, 1'b0, 13'h0042);
    rd_chk(2'h3, 13'h0001, 16'h0f0f);
    chk(32'(refs > n), 32'h1);
    n = refs;
    repeat (312) @(posedge pclk);
    chk(32'(refs > n), 32'h1);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_write();
    t_pre();
    t_sref();
    summarize();
  end
endmodule
